// ---- sfh_pkg.sv ----
// constants, opcodes and command framing table for the serial flash host
package sfh_pkg;

  localparam int REF_PERIOD_NS = 40;
  localparam int SCK_PERIOD_NS = 320;
  localparam int SCK_DIV = SCK_PERIOD_NS / REF_PERIOD_NS;
  localparam int SCK_HZ = 1_000_000_000 / SCK_PERIOD_NS;
  localparam int LOW_FREQUENCY_READ_LIMIT_HZ = 40_000_000;
  localparam int SPI_CLK_LIMIT_HZ = 85_000_000;
  localparam int T_CS_HIGH_NS = 100;

  localparam logic [2:0] PH_LAST = 3'(SCK_DIV - 1);
  localparam logic [2:0] PH_SCK_UP = 3'(SCK_DIV / 2 - 1);
  localparam logic [2:0] CLK_LAST_X1 = 3'h7;
  localparam logic [2:0] CLK_LAST_X2 = 3'h3;
  localparam logic [2:0] CLK_LAST_X4 = 3'h1;
  localparam logic [3:0] CS_HIGH_CYC = 4'((T_CS_HIGH_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS);
  localparam logic [7:0] DUMMY_BYTE_CYC = 8'(8 * SCK_DIV);
  localparam logic [20:0] ADDR_TOP = 21'h1FFFFF;
  localparam logic [8:0] MAX_PAGE = 9'h100;
  localparam logic [8:0] ID_MAX = 9'h005;
  localparam logic [3:0] IO_IDLE = 4'hC;
  localparam logic [3:0] OE_IDLE = 4'h2;

  localparam logic [7:0] OP_READ_FAST2 = 8'h1B;
  localparam logic [7:0] OP_READ_FAST1 = 8'h0B;
  localparam logic [7:0] OP_READ_SLOW = 8'h03;
  localparam logic [7:0] OP_READ_DUAL = 8'h3B;
  localparam logic [7:0] OP_READ_QUAD = 8'h6B;
  localparam logic [7:0] OP_ERASE_4K = 8'h20;
  localparam logic [7:0] OP_ERASE_32K = 8'h52;
  localparam logic [7:0] OP_ERASE_64K = 8'hD8;
  localparam logic [7:0] OP_ERASE_ALL_A = 8'h60;
  localparam logic [7:0] OP_ERASE_ALL_B = 8'hC7;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_PROG_DUAL = 8'hA2;
  localparam logic [7:0] OP_PROG_QUAD = 8'h32;
  localparam logic [7:0] OP_SUSPEND = 8'hB0;
  localparam logic [7:0] OP_RESUME = 8'hD0;
  localparam logic [7:0] OP_WR_EN = 8'h06;
  localparam logic [7:0] OP_WR_DIS = 8'h04;
  localparam logic [7:0] OP_PROTECT = 8'h36;
  localparam logic [7:0] OP_UNPROTECT = 8'h39;
  localparam logic [7:0] OP_RD_PROT = 8'h3C;
  localparam logic [7:0] OP_LOCK = 8'h33;
  localparam logic [7:0] OP_FREEZE = 8'h34;
  localparam logic [7:0] OP_RD_LOCK = 8'h35;
  localparam logic [7:0] OP_OTP_PROG = 8'h9B;
  localparam logic [7:0] OP_OTP_READ = 8'h77;
  localparam logic [7:0] OP_RD_STAT = 8'h05;
  localparam logic [7:0] OP_WR_STAT1 = 8'h01;
  localparam logic [7:0] OP_WR_STAT2 = 8'h31;
  localparam logic [7:0] OP_RD_CFG = 8'h3F;
  localparam logic [7:0] OP_WR_CFG = 8'h3E;
  localparam logic [7:0] OP_SOFT_RST = 8'hF0;
  localparam logic [7:0] OP_READ_ID = 8'h9F;
  localparam logic [7:0] OP_SLEEP = 8'hB9;
  localparam logic [7:0] OP_WAKE = 8'hAB;

  typedef enum logic [1:0] {
    DIR_NONE = 2'h0,
    DIR_WR   = 2'h1,
    DIR_RD   = 2'h2
  } sfh_dir_e;

  typedef struct packed {
    logic        ok;
    logic [1:0]  nadr;
    logic [1:0]  ndum;
    sfh_dir_e    dir;
    logic [2:0]  lanes;
    logic [8:0]  maxlen;
  } sfh_fmt_s;

  function automatic sfh_fmt_s sfh_mk(input logic [1:0] na, input logic [1:0] nd,
                                      input sfh_dir_e d, input logic [2:0] ln,
                                      input logic [8:0] ml);
    sfh_mk = '{ok: 1'b1, nadr: na, ndum: nd, dir: d, lanes: ln, maxlen: ml};
  endfunction

  // framing of every known opcode; anything else is refused
  function automatic sfh_fmt_s sfh_decode(input logic [7:0] op);
    case (op)
      OP_READ_FAST2, OP_OTP_READ: sfh_decode = sfh_mk(2'h3, 2'h2, DIR_RD, 3'h1, 9'h000);
      OP_READ_FAST1: sfh_decode = sfh_mk(2'h3, 2'h1, DIR_RD, 3'h1, 9'h000);
      OP_READ_SLOW, OP_RD_PROT, OP_RD_LOCK: sfh_decode = sfh_mk(2'h3, 2'h0, DIR_RD, 3'h1, 9'h000);
      OP_READ_DUAL: sfh_decode = sfh_mk(2'h3, 2'h1, DIR_RD, 3'h2, 9'h000);
      OP_READ_QUAD: sfh_decode = sfh_mk(2'h3, 2'h1, DIR_RD, 3'h4, 9'h000);
      OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K, OP_PROTECT, OP_UNPROTECT:
        sfh_decode = sfh_mk(2'h3, 2'h0, DIR_NONE, 3'h1, 9'h000);
      OP_ERASE_ALL_A, OP_ERASE_ALL_B, OP_SUSPEND, OP_RESUME, OP_WR_EN, OP_WR_DIS,
      OP_SLEEP, OP_WAKE: sfh_decode = sfh_mk(2'h0, 2'h0, DIR_NONE, 3'h1, 9'h000);
      OP_PROG, OP_OTP_PROG: sfh_decode = sfh_mk(2'h3, 2'h0, DIR_WR, 3'h1, MAX_PAGE);
      OP_PROG_DUAL: sfh_decode = sfh_mk(2'h3, 2'h0, DIR_WR, 3'h2, MAX_PAGE);
      OP_PROG_QUAD: sfh_decode = sfh_mk(2'h3, 2'h0, DIR_WR, 3'h4, MAX_PAGE);
      OP_LOCK, OP_FREEZE: sfh_decode = sfh_mk(2'h3, 2'h0, DIR_WR, 3'h1, 9'h001);
      OP_RD_STAT, OP_RD_CFG: sfh_decode = sfh_mk(2'h0, 2'h0, DIR_RD, 3'h1, 9'h000);
      OP_WR_STAT1, OP_WR_STAT2, OP_WR_CFG, OP_SOFT_RST:
        sfh_decode = sfh_mk(2'h0, 2'h0, DIR_WR, 3'h1, 9'h001);
      OP_READ_ID: sfh_decode = sfh_mk(2'h0, 2'h0, DIR_RD, 3'h1, ID_MAX);
      default: sfh_decode = '0;
    endcase
  endfunction

endpackage

// ---- sfh_sync3.sv ----
// three-stage synchroniser for the flash data pins
`timescale 1ns/1ps
`default_nettype none
module sfh_sync3 (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // pins and result
  input  wire logic [3:0] pin_in,
  output logic      [3:0] pin_sync
);
  logic [3:0] s1;
  logic [3:0] s2;
  logic [3:0] s3;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s1 <= 4'h0;
      s2 <= 4'h0;
      s3 <= 4'h0;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // per bit, a change counts once the last two stages agree
  genvar g;
  for (g = 0; g < 4; g++) begin : g_bit
    always_ff @(posedge ref_clk) begin
      if (reset) begin
        pin_sync[g] <= 1'b0;
      end else if (s2[g] == s3[g]) begin
        pin_sync[g] <= s3[g];
      end
    end
  end
endmodule
`default_nettype wire

// ---- sfh_ctrl.sv ----
// host controller that frames serial flash commands and streams data
// Operation
// - 1Bh read: three address bytes, two dummy bytes, then data.
// - 0Bh read: three address bytes, exactly one dummy byte, then data.
// - 03h read: no dummy byte, only at the low read clock limit.
// - 1Bh above normal clock only with high-speed clocking protocol.
// - chip select may rise at any point of a read.
// - block erases take three address bytes; others take nothing.
// - 02h program: three address bytes, 1 to 256 data bytes.
// - A2h dual program: same framing as single program.
// - 32h quad program: three address bytes, one or more data bytes.
// - protect/unprotect address only; 3Ch reads; 06h/04h bare.
// - 33h and 34h take three address bytes and one data byte.
// - 35h takes three address bytes then returns data.
// - 9Bh takes three address bytes then data bytes.
// - 77h takes three address bytes, two dummies, returns data.
// - 05h/3Fh return data; 31h/3Eh take one data byte.
// - 9Fh returns one to five bytes at the normal clock limit.
// - B9h/ABh bare; F0h takes one data byte.
// - 3Bh dual read: one dummy, two bits per clock, MSB on line one.
// - 6Bh quad read: one dummy, four bits per clock, MSB on line three.
`timescale 1ns/1ps
`default_nettype none
module sfh_ctrl
  import sfh_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // command
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [7:0]  cmd_opcode,
  input  wire logic [23:0] cmd_addr,
  input  wire logic [8:0]  cmd_len,
  input  wire logic        cmd_abort,
  output logic             cmd_done,
  output logic             cmd_err,
  // write data
  input  wire logic        wr_valid,
  input  wire logic [7:0]  wr_data,
  output logic             wr_ready,
  // read data
  output logic             rd_valid,
  output logic [7:0]       rd_data,
  output logic [20:0]      rd_addr,
  // flash pins
  output logic             flash_cs_n,
  output logic             flash_sck,
  output logic [3:0]       flash_io_out,
  output logic [3:0]       flash_io_oe_n,
  input  wire logic [3:0]  flash_io_in
);
  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_OPC   = 8'h02,
    ST_ADDR  = 8'h04,
    ST_DUMMY = 8'h08,
    ST_WLOAD = 8'h10,
    ST_WDATA = 8'h20,
    ST_RDATA = 8'h40,
    ST_END   = 8'h80
  } sfh_state_e;

  sfh_state_e  st;
  sfh_state_e  tgt;
  sfh_state_e  data_st;
  sfh_fmt_s    fmt;
  sfh_fmt_s    dec;
  logic [7:0]  op_q;
  logic [2:0]  phase;
  logic [2:0]  clk_cnt;
  logic [2:0]  cur_w;
  logic [2:0]  last_clk;
  logic [1:0]  idx;
  logic [8:0]  left;
  logic [8:0]  len_sel;
  logic        unlim;
  logic [7:0]  tx;
  logic [7:0]  rx;
  logic [7:0]  rx_next;
  logic [23:0] addr_q;
  logic [20:0] arr_cnt;
  logic [3:0]  hold;
  logic [3:0]  io_s;
  logic        shifting;
  logic        tick;
  logic        byte_end;
  logic        accept;

  sfh_sync3 i_sfh_sync3 (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .pin_in   (flash_io_in),
    .pin_sync (io_s)
  );

  // host lanes for a byte: io3/io2 held high outside quad mode
  function automatic logic [3:0] lane_out(input logic [7:0] b, input logic [2:0] w);
    if (w == 3'h4) begin
      lane_out = b[7:4];
    end else if (w == 3'h2) begin
      lane_out = {2'b11, b[7:6]};
    end else begin
      lane_out = {3'b110, b[7]};
    end
  endfunction

  // release lines the device drives; dummy phase already released
  function automatic logic [3:0] oe_map(input sfh_state_e s, input sfh_fmt_s f);
    logic rd_side;
    rd_side = (s == ST_RDATA) || (s == ST_DUMMY && f.dir == DIR_RD);
    if (rd_side && f.lanes == 3'h4) begin
      oe_map = 4'hF;
    end else if (rd_side && f.lanes == 3'h2) begin
      oe_map = 4'h3;
    end else if ((s == ST_WDATA || s == ST_WLOAD) && f.lanes != 3'h1) begin
      oe_map = 4'h0;
    end else begin
      oe_map = OE_IDLE;
    end
  endfunction

  assign dec      = sfh_decode(cmd_opcode);
  assign accept   = cmd_valid && cmd_ready;
  assign shifting = (st == ST_OPC) || (st == ST_ADDR) || (st == ST_DUMMY) ||
                    (st == ST_WDATA) || (st == ST_RDATA);
  assign tick     = shifting && (phase == PH_LAST);
  assign cur_w    = (st == ST_WDATA || st == ST_RDATA) ? fmt.lanes : 3'h1;
  assign last_clk = (cur_w == 3'h4) ? CLK_LAST_X4 :
                    (cur_w == 3'h2) ? CLK_LAST_X2 : CLK_LAST_X1;
  assign byte_end = tick && (clk_cnt == last_clk);
  assign data_st  = (fmt.dir == DIR_WR) ? ST_WLOAD :
                    (fmt.dir == DIR_RD) ? ST_RDATA : ST_END;

  // stage after the byte now finishing
  always_comb begin
    tgt = st;
    case (st)
      ST_OPC:   tgt = (fmt.nadr != 2'h0) ? ST_ADDR : data_st;
      ST_ADDR:  tgt = (idx != 2'h2) ? ST_ADDR : (fmt.ndum != 2'h0) ? ST_DUMMY : data_st;
      ST_DUMMY: tgt = (idx != fmt.ndum - 2'h1) ? ST_DUMMY : data_st;
      ST_WDATA: tgt = (left == 9'h000) ? ST_END : ST_WLOAD;
      ST_RDATA: tgt = (!unlim && left == 9'h001) ? ST_END : ST_RDATA;
      default:  tgt = st;
    endcase
  end

  // length clamp per opcode class
  always_comb begin
    len_sel = 9'h000;
    if (dec.dir == DIR_WR) begin
      len_sel = (cmd_len == 9'h000) ? 9'h001 : cmd_len;
      if (len_sel > dec.maxlen) len_sel = dec.maxlen;
    end else if (dec.dir == DIR_RD) begin
      len_sel = (cmd_len == 9'h000 || (dec.maxlen != 9'h000 && cmd_len > dec.maxlen)) ?
                dec.maxlen : cmd_len;
    end
  end

  // incoming bits per lane width, MSB first
  always_comb begin
    case (cur_w)
      3'h4:    rx_next = {rx[3:0], io_s};
      3'h2:    rx_next = {rx[5:0], io_s[1:0]};
      default: rx_next = {rx[6:0], io_s[1]};
    endcase
  end

  // serial clock divider and bit counter
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      phase   <= 3'h0;
      clk_cnt <= 3'h0;
    end else if (!shifting) begin
      phase   <= 3'h0;
      clk_cnt <= 3'h0;
    end else begin
      phase <= phase + 3'h1;
      if (tick) clk_cnt <= byte_end ? 3'h0 : clk_cnt + 3'h1;
    end
  end

  // command sequencing and outgoing bits
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st           <= ST_IDLE;
      fmt          <= '0;
      op_q         <= 8'h00;
      idx          <= 2'h0;
      left         <= 9'h000;
      unlim        <= 1'b0;
      tx           <= 8'h00;
      addr_q       <= 24'h000000;
      hold         <= 4'h0;
      flash_cs_n   <= 1'b1;
      flash_io_out <= IO_IDLE;
      cmd_ready    <= 1'b0;
      cmd_err      <= 1'b0;
      cmd_done     <= 1'b0;
      wr_ready     <= 1'b0;
    end else begin
      cmd_err  <= 1'b0;
      cmd_done <= 1'b0;
      case (st)
        ST_IDLE: begin
          cmd_ready <= 1'b1;
          if (accept) begin
            cmd_ready <= 1'b0;
            if (!dec.ok) begin
              cmd_err <= 1'b1;
            end else begin
              st           <= ST_OPC;
              fmt          <= dec;
              op_q         <= cmd_opcode;
              addr_q       <= {3'h0, cmd_addr[20:0]};
              left         <= len_sel;
              unlim        <= (dec.dir == DIR_RD) && (len_sel == 9'h000);
              flash_cs_n   <= 1'b0;
              flash_io_out <= lane_out(cmd_opcode, 3'h1);
              tx           <= {cmd_opcode[6:0], 1'b0};
            end
          end
        end
        ST_END: begin
          flash_io_out <= IO_IDLE;
          hold         <= hold + 4'h1;
          if (hold == CS_HIGH_CYC) begin
            st       <= ST_IDLE;
            cmd_done <= 1'b1;
          end
        end
        ST_WLOAD: begin
          if (cmd_abort) begin
            st         <= ST_END;
            flash_cs_n <= 1'b1;
            hold       <= 4'h0;
            wr_ready   <= 1'b0;
          end else if (wr_valid && wr_ready) begin
            wr_ready     <= 1'b0;
            flash_io_out <= lane_out(wr_data, fmt.lanes);
            tx           <= wr_data << fmt.lanes;
            left         <= left - 9'h001;
            st           <= ST_WDATA;
          end
        end
        default: begin
          if (cmd_abort) begin
            st         <= ST_END;
            flash_cs_n <= 1'b1;
            hold       <= 4'h0;
          end else if (byte_end) begin
            st  <= tgt;
            idx <= (tgt == st) ? idx + 2'h1 : 2'h0;
            if (st == ST_RDATA && !unlim) left <= left - 9'h001;
            if (tgt == ST_ADDR) begin
              flash_io_out <= lane_out(addr_q[23:16], 3'h1);
              tx           <= {addr_q[22:16], 1'b0};
              addr_q       <= {addr_q[15:0], 8'h00};
            end else if (tgt == ST_DUMMY) begin
              flash_io_out <= lane_out(8'h00, 3'h1);
              tx           <= 8'h00;
            end else if (tgt == ST_WLOAD) begin
              wr_ready <= 1'b1;
            end else if (tgt == ST_END) begin
              flash_cs_n <= 1'b1;
              hold       <= 4'h0;
            end
          end else if (tick) begin
            flash_io_out <= lane_out(tx, cur_w);
            tx           <= tx << cur_w;
          end
        end
      endcase
    end
  end

  // read data assembly and array address tracking
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rx       <= 8'h00;
      rd_valid <= 1'b0;
      rd_data  <= 8'h00;
      rd_addr  <= 21'h000000;
      arr_cnt  <= 21'h000000;
    end else begin
      rd_valid <= 1'b0;
      if (accept) begin
        arr_cnt <= cmd_addr[20:0];
      end else if (st == ST_RDATA && tick && !cmd_abort) begin
        rx <= rx_next;
        if (byte_end) begin
          rd_valid <= 1'b1;
          rd_data  <= rx_next;
          rd_addr  <= arr_cnt;
          arr_cnt  <= (arr_cnt == ADDR_TOP) ? '0 : arr_cnt + 21'h000001;
        end
      end
    end
  end

  // clock and output-enable pins
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      flash_sck     <= 1'b0;
      flash_io_oe_n <= OE_IDLE;
    end else begin
      flash_sck     <= shifting && !cmd_abort && phase >= PH_SCK_UP && phase != PH_LAST;
      flash_io_oe_n <= oe_map(st, fmt);
    end
  end

  // helper counters for checks
  logic [7:0] dum_cyc;
  logic [8:0] wr_cnt;
  logic [8:0] rd_cnt;

  always_ff @(posedge ref_clk) begin
    if (reset || accept) begin
      dum_cyc <= 8'h00;
      wr_cnt  <= 9'h000;
      rd_cnt  <= 9'h000;
    end else begin
      if (st == ST_DUMMY) dum_cyc <= dum_cyc + 8'h01;
      if (wr_valid && wr_ready) wr_cnt <= wr_cnt + 9'h001;
      if (rd_valid) rd_cnt <= rd_cnt + 9'h001;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_read_start;
    $rose(st == ST_RDATA);
  endsequence
  sequence s_abort;
    cmd_abort && shifting;
  endsequence
  sequence s_dual_byte;
    rd_valid && fmt.lanes == 3'h2;
  endsequence
  sequence s_quad_byte;
    rd_valid && fmt.lanes == 3'h4;
  endsequence

  property p_fast2_dummy;
    s_read_start and (op_q == OP_READ_FAST2) |-> dum_cyc == 8'(2 * DUMMY_BYTE_CYC);
  endproperty
  a_fast2_dummy: assert property (p_fast2_dummy) else $error("1Bh dummy length wrong");

  property p_fast1_dummy;
    s_read_start and (op_q == OP_READ_FAST1) |-> dum_cyc == DUMMY_BYTE_CYC;
  endproperty
  a_fast1_dummy: assert property (p_fast1_dummy) else $error("0Bh dummy length wrong");

  property p_slow_rate;
    accept && cmd_opcode == OP_READ_SLOW |-> SCK_HZ <= LOW_FREQUENCY_READ_LIMIT_HZ;
  endproperty
  a_slow_rate: assert property (p_slow_rate) else $error("03h clock too fast");

  property p_normal_rate;
    accept && (cmd_opcode == OP_READ_FAST2 || cmd_opcode == OP_READ_ID)
      |-> SCK_HZ <= SPI_CLK_LIMIT_HZ;
  endproperty
  a_normal_rate: assert property (p_normal_rate) else $error("clock above limit");

  property p_wrap;
    st == ST_RDATA && byte_end && !cmd_abort && arr_cnt == ADDR_TOP |=> arr_cnt == '0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("address did not wrap");

  property p_abort;
    s_abort |=> flash_cs_n && !flash_sck ##1 st == ST_END;
  endproperty
  a_abort: assert property (p_abort) else $error("abort did not end frame");

  property p_page;
    !flash_cs_n |-> wr_cnt <= MAX_PAGE;
  endproperty
  a_page: assert property (p_page) else $error("more than a page sent");

  property p_lock_one;
    $rose(st == ST_END) && (op_q == OP_LOCK || op_q == OP_FREEZE) && !$past(cmd_abort)
      |-> wr_cnt == 9'h001;
  endproperty
  a_lock_one: assert property (p_lock_one) else $error("lockdown byte count wrong");

  property p_id_len;
    rd_valid && op_q == OP_READ_ID |-> rd_cnt < ID_MAX;
  endproperty
  a_id_len: assert property (p_id_len) else $error("too many id bytes");

  property p_dual_rate;
    s_dual_byte |-> ##32 (rd_valid || st != ST_RDATA);
  endproperty
  a_dual_rate: assert property (p_dual_rate) else $error("dual byte spacing wrong");

  property p_quad_rate;
    s_quad_byte |-> ##16 (rd_valid || st != ST_RDATA);
  endproperty
  a_quad_rate: assert property (p_quad_rate) else $error("quad byte spacing wrong");

  property p_refuse;
    accept && !dec.ok |=> cmd_err && flash_cs_n && st == ST_IDLE;
  endproperty
  a_refuse: assert property (p_refuse) else $error("unknown opcode started");

  property p_addr_top;
    $rose(st == ST_ADDR) |-> flash_io_out[0] == 1'b0 && tx[7:6] == 2'b00;
  endproperty
  a_addr_top: assert property (p_addr_top) else $error("top address bits not zero");
endmodule
`default_nettype wire

// ---- sfh_flash_model.sv ----
// behavioural serial flash device facing the host controller
`timescale 1ns/1ps
`default_nettype none
module sfh_flash_model (
  // flash pins
  input  wire logic       cs_n,
  input  wire logic       sck,
  input  wire logic [3:0] io_out,
  input  wire logic [3:0] io_oe_n,
  output logic      [3:0] io_in
);
  logic [7:0]  op = 8'h00;
  logic [23:0] adr;
  logic [63:0] sr;
  logic [20:0] ptr;
  logic [7:0]  b;
  logic [3:0]  drv = 4'h0;
  logic [3:0]  den = 4'h0;
  logic        cs_q = 1'b1;
  int          nr = 0;
  int          k;
  function automatic logic [7:0] dat(input logic [20:0] a);
    return a[7:0] ^ a[20:13];
  endfunction
  // clocks before read data, zero for no read
  function automatic int hdr(input logic [7:0] o);
    case (o)
      8'h03, 8'h35, 8'h3C: return 32;
      8'h0B, 8'h3B, 8'h6B: return 40;
      8'h1B, 8'h77: return 48;
      8'h05, 8'h3F, 8'h9F: return 8;
      default: return 0;
    endcase
  endfunction
  function automatic int lanes(input logic [7:0] o);
    return (o == 8'h3B || o == 8'hA2) ? 2 : (o == 8'h6B || o == 8'h32) ? 4 : 1;
  endfunction
  // released lines the model drives show its last driven level; other released lines show the inverse
  assign io_in = (~io_oe_n & io_out) | (io_oe_n & den & drv) | (io_oe_n & ~den & ~drv);
  // one process for all pin events: frame open, frame close, sample on rise, drive on fall
  always @(negedge cs_n or posedge cs_n or posedge sck or negedge sck) begin
    if (cs_n !== cs_q) begin
      cs_q = cs_n;
      if (!cs_n) begin
        nr = 0;
        op = 8'h00;
        ptr = 21'h0;
      end else begin
        den = 4'h0;
      end
    end else if (!cs_n && sck) begin
      k = (nr >= 32) ? lanes(op) : 1;
      sr = (sr << k) | 64'(io_in & 4'((1 << k) - 1));
      nr = nr + 1;
      if (nr == 8) op = sr[7:0];
      if (nr == 32) begin
        adr = sr[23:0];
        ptr = sr[20:0];
      end
    end else if (!cs_n && hdr(op) != 0 && nr >= hdr(op)) begin
      k = (nr - hdr(op)) % (8 / lanes(op));
      b = dat(ptr) << (k * lanes(op));
      den = (lanes(op) == 4) ? 4'hF : (lanes(op) == 2) ? 4'h3 : 4'h2;
      drv = (lanes(op) == 4) ? b[7:4] : (lanes(op) == 2) ? {2'h0, b[7:6]} : {2'h0, b[7], 1'b0};
      if (k == 8 / lanes(op) - 1) ptr = ptr + 21'h1;
    end
  end
endmodule
`default_nettype wire

// ---- sfh_ctrl_bench.sv ----
// self-checking bench for the serial flash host controller
`timescale 1ns/1ps
`default_nettype none
module sfh_ctrl_bench;
  import sfh_pkg::*;
  logic        ref_clk = 1'b0, reset = 1'b1, cmd_valid = 1'b0, cmd_abort = 1'b0;
  logic        wr_valid = 1'b0, cmd_ready, cmd_done, cmd_err, wr_ready, rd_valid;
  logic        flash_cs_n, flash_sck, chk = 1'b0;
  logic [7:0]  cmd_opcode = 8'h00, wr_data = 8'h00, rd_data;
  logic [23:0] cmd_addr = 24'h0;
  logic [8:0]  cmd_len = 9'h0;
  logic [20:0] rd_addr, exp_a;
  logic [3:0]  io_out, io_oe_n, io_in;
  int          fail_count = 0, samples_checked = 0, rd_n = 0, cs_lo;
  // op, address bytes, dummies, lanes (8 = write), bytes, length
  localparam logic [31:0] TAB [34] = '{32'h03301303, 32'h0B311303, 32'h1B321303,
    32'h3B312303, 32'h6B314303, 32'h77321202, 32'h35301101, 32'h3C301101, 32'h05001202,
    32'h3F001101, 32'h9F001500, 32'h02309202, 32'hA230A202, 32'h3230C303, 32'h9B309101,
    32'h33309101, 32'h34309103, 32'h01009101, 32'h31009101, 32'h3E009101, 32'hF0009101,
    32'h20301000, 32'h52301000, 32'hD8301000, 32'h36301000, 32'h39301000, 32'h60001000,
    32'hC7001000, 32'hB0001000, 32'hD0001000, 32'h06001000, 32'h04001000, 32'hB9001000,
    32'hAB001000};
  always #20 ref_clk = ~ref_clk;
  sfh_ctrl i_sfh_ctrl (.ref_clk(ref_clk), .reset(reset), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_opcode(cmd_opcode), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
    .cmd_abort(cmd_abort), .cmd_done(cmd_done), .cmd_err(cmd_err), .wr_valid(wr_valid),
    .wr_data(wr_data), .wr_ready(wr_ready), .rd_valid(rd_valid), .rd_data(rd_data),
    .rd_addr(rd_addr), .flash_cs_n(flash_cs_n), .flash_sck(flash_sck),
    .flash_io_out(io_out), .flash_io_oe_n(io_oe_n), .flash_io_in(io_in));
  sfh_flash_model i_sfh_flash_model (.cs_n(flash_cs_n), .sck(flash_sck), .io_out(io_out),
    .io_oe_n(io_oe_n), .io_in(io_in));
  function automatic logic [7:0] dat(input logic [20:0] a);
    return a[7:0] ^ a[20:13];
  endfunction
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // array read bytes against the model's contents
  always @(posedge ref_clk) if (rd_valid === 1'b1) begin
    rd_n++;
    if (chk) begin
      check(rd_data, dat(exp_a));
      check(rd_addr, exp_a);
      exp_a++;
    end
  end
  task automatic run(input logic [7:0] op, input logic [8:0] len, input int ab, output logic err);
    int t;
    rd_n = 0;
    cs_lo = 0;
    exp_a = 21'h1FFFFE;
    chk = op inside {8'h03, 8'h0B, 8'h1B, 8'h3B, 8'h6B};
    cmd_opcode <= op;
    cmd_addr <= 24'hFFFFFE;
    cmd_len <= len;
    cmd_valid <= 1'b1;
    wr_valid <= 1'b1;
    wr_data <= 8'h5A;
    do @(posedge ref_clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    for (t = 0; t < 5000; t++) begin
      @(posedge ref_clk);
      if (flash_cs_n !== 1'b1) cs_lo++;
      if (wr_ready === 1'b1) wr_data <= wr_data + 8'h01;
      if (t == ab) cmd_abort <= 1'b1;
      if (cmd_done === 1'b1 || cmd_err === 1'b1) break;
    end
    err = cmd_err;
    if (t == 5000) fail_count++;
    cmd_abort <= 1'b0;
    wr_valid <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic framing;
    logic [31:0] e;
    logic        err;
    int          clocks;
    foreach (TAB[i]) begin
      e = TAB[i];
      run(e[31:24], {1'b0, e[7:0]}, -1, err);
      clocks = 8 * (1 + e[23:20] + e[19:16]) + 8 * e[11:8] / e[14:12];
      check(i_sfh_flash_model.op, e[31:24]);
      check(24'(i_sfh_flash_model.nr), 24'(clocks));
      check(24'(rd_n), e[15] ? 24'h0 : 24'(e[11:8]));
      if (e[23:20] != 4'h0) check(i_sfh_flash_model.adr, 24'h1FFFFE);
      if (e[15]) check(i_sfh_flash_model.sr[7:0], wr_data - 8'h01);
    end
  endtask
  task automatic refuse_and_abort;
    logic err;
    run(8'hFF, 9'h001, -1, err);
    check(err, 1'b1);
    check(24'(cs_lo), 24'h0);
    run(8'h0B, 9'h000, 500, err);
    check(24'(rd_n), 24'h2);
    check(flash_cs_n, 1'b1);
  endtask
  task automatic summarize;
    if (fail_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    framing();
    refuse_and_abort();
    summarize();
  end
  initial begin
    #(80_000 * 40);
    fail_count++;
    summarize();
  end
endmodule
`default_nettype wire
